// File: common/pin_mux_defs.vh
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH
// Register byte offsets
`define OFS_PORT_DATA 8'h00
`define OFS_PORT_DIR 8'h04
`define OFS_PORT_PULL 8'h08
`define OFS_PORT_WAKE 8'h0c
`define OFS_SEL_LOW 8'h10
`define OFS_SEL_HIGH 8'h14
`define OFS_SRC_SEL 8'h18
`define OFS_BIT_OP 8'h1c
`define OFS_CTRL 8'h20
`define OFS_IRQ_STAT 8'h24
`define OFS_IRQ_MASK 8'h28
`define OFS_PIN_LEVEL 8'h2c
// Reset values
`define RST_PORT_DATA 8'hff
`define RST_PORT_DIR 8'hff
`define RST_ZERO 8'h00
// Writable masks of the select and source registers per variant
`define SEL_LOW_MASK_SMALL 8'hcc
`define SEL_LOW_MASK_LARGE 8'hff
`define SEL_HIGH_MASK 8'hcf
`define SRC_SEL_MASK 8'h03
// Bit-op register fields
`define BITOP_IDX_LSB 0
`define BITOP_SET_BIT 4
`define BITOP_DIR_BIT 5
// Control register fields
`define CTRL_HALT_BIT 0
// Select codes
`define CODE_ALT2 2'b10
`define CODE_ALT3 2'b11
// Status bits
`define IRQ_WAKE_BIT 0
`define IRQ_BITOP_BIT 1
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: dv/pin_mux_checker_properties.sv
`timescale 1ns/1ps
// Pin routing and read channel timing seen at the ports
module pin_mux_checker (
  input wire REF_CLK,
  input wire RST,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [7:0] PIN_IN,
  input wire [7:0] PIN_OUT,
  input wire [7:0] PIN_OE,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire SDA_IN,
  input wire SDA_SEL,
  input wire SCL_OUT,
  input wire SCL_OE,
  input wire SCL_IN,
  input wire SCL_SEL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Pins come out of reset as inputs
  property p_rst_in;
    $fell(RST) |-> PIN_OE == 8'h00;
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("pin driven at reset");
  property p_sda_in;
    SDA_IN == PIN_IN[2];
  endproperty
  a_sda_in: assert property (p_sda_in) else $error("data line input");
  property p_scl_in;
    SCL_IN == PIN_IN[0];
  endproperty
  a_scl_in: assert property (p_scl_in) else $error("clock line input");
  // Open-drain lines only ever pull low
  property p_sda_low;
    SDA_SEL && SDA_OE && !SDA_OUT |-> PIN_OE[2] && !PIN_OUT[2];
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data line low");
  property p_scl_low;
    SCL_SEL && SCL_OE && !SCL_OUT |-> PIN_OE[0] && !PIN_OUT[0];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock line low");
  // Read answers one cycle after the address is taken
  property p_rd_ans;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
  property p_rd_done;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not retired");
  property p_ar_ref;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("second read taken");
  c_rd: cover property (S_AXI_ARVALID && S_AXI_ARREADY);
  c_sda: cover property (SDA_SEL && SDA_OE && !SDA_OUT);
  c_scl: cover property (SCL_SEL && SCL_OE && !SCL_OUT);
endmodule

bind port_a_pin_function_mux pin_mux_checker chk_i (.*);

// File: dv/pin_partner.sv
`timescale 1ns/1ps
// Switches on the port pins
module pin_partner (
  input wire [7:0] PIN_OUT,
  input wire [7:0] PIN_OE,
  input wire [7:0] EXT_VAL,
  output wire [7:0] PIN_IN
);
  // Device drive wins, so open-drain lows reach the input too
  assign PIN_IN = PIN_OE & PIN_OUT | ~PIN_OE & EXT_VAL;
endmodule

// File: dv/port_a_pin_function_mux_test.sv
`timescale 1ns/1ps
module port_a_pin_function_mux_test;
  logic REF_CLK = 0, RST = 1, CLK_EN = 1, TIMER_COMPARE_OUT = 0;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic SDA_OUT = 0, SDA_OE = 0, SCL_OUT = 0, SCL_OE = 0;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, EXT_VAL = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, q;
  logic [3:0] S_AXI_WSTRB = 4'hf, TOUCH_KEY_SEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [7:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULL_EN;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, TIMER_EXT_CLOCK_IN, EXT_IRQ_IN;
  logic SDA_IN, SCL_IN, SDA_SEL, SCL_SEL, WAKE, IRQ;
  int failures = 0, checked = 0, m[16], i, c;

  port_a_pin_function_mux dut (.*);
  pin_partner pins (.*);

  logic [3:0] key_small;
  // Small variant on the same bus; only its key routing is compared
  port_a_pin_function_mux #(.LARGE(0)) dut_small (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .CLK_EN(CLK_EN),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(),
    .S_AXI_BRESP(),
    .S_AXI_BVALID(),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(),
    .S_AXI_RDATA(),
    .S_AXI_RRESP(),
    .S_AXI_RVALID(),
    .S_AXI_RREADY(S_AXI_RREADY),
    .PIN_IN(PIN_IN),
    .PIN_OUT(),
    .PIN_OE(),
    .PIN_PULL_EN(),
    .TOUCH_KEY_SEL(key_small),
    .TIMER_COMPARE_OUT(TIMER_COMPARE_OUT),
    .TIMER_EXT_CLOCK_IN(),
    .EXT_IRQ_IN(),
    .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE),
    .SDA_IN(),
    .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE),
    .SCL_IN(),
    .SDA_SEL(),
    .SCL_SEL(),
    .WAKE(),
    .IRQ()
  );

  // 100 MHz clock
  always #5 REF_CLK = ~REF_CLK;

  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input [33:0] g, input [33:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One bus transfer; readies sampled mid-cycle, acted on at the edge
  task xfer(input bit w, input [7:0] a, input [7:0] d);
    int n;
    bit aw, wd, ar, dn;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {3{w}};
    {S_AXI_ARVALID, S_AXI_RREADY} <= {2{!w}};
    dn = 0;
    for (n = 0; n < 50 && !dn; n++) begin
      @(negedge REF_CLK);
      aw = S_AXI_AWREADY;
      wd = S_AXI_WREADY;
      ar = S_AXI_ARREADY;
      dn = w ? S_AXI_BVALID : S_AXI_RVALID;
      q = S_AXI_RDATA;
      rsp = w ? S_AXI_BRESP : S_AXI_RRESP;
      @(posedge REF_CLK);
      if (aw) S_AXI_AWVALID <= 0;
      if (wd) S_AXI_WVALID <= 0;
      if (ar) S_AXI_ARVALID <= 0;
    end
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
    if (!dn) begin
      failures++;
      summarize;
    end
  endtask

  // Write and mirror it into the model; bit-op reads the port or direction first
  task wr(input [7:0] a, input [7:0] d);
    int k, p;
    k = a >> 2;
    p = d[5] ? m[1] : m[1] & EXT_VAL | ~m[1] & m[0];
    xfer(1, a, d);
    chk(rsp, 0);
    if (k == 7) begin
      p[d[2:0]] = d[4];
      m[d[5]] = p & 8'hff;
      m[9] |= 2;
    end else if (k == 9)
      m[9] &= ~d;
    else
      m[k] = d & (k == 5 ? 8'hcf : k == 6 ? 8'h03 : k == 8 ? 8'h01 : 8'hff);
  endtask

  // Input pins read their level, output pins their latch
  task rd(input [7:0] a);
    int k;
    k = a >> 2;
    xfer(0, a, 0);
    chk({rsp, q}, k ? m[k] : m[1] & EXT_VAL | ~m[1] & m[0]);
  endtask

  // Main sequence
  initial begin
    void'($urandom(4));
    EXT_VAL = $urandom;
    m = '{default: 0};
    m[0] = 255;
    m[1] = 255;
    repeat (12) @(posedge REF_CLK);
    RST <= 0;
    for (i = 0; i < 7; i++) rd(4 * i);
    // Source pins across codes, pins left as inputs
    for (c = 0; c < 4; c++) begin
      wr(8'h18, c);
      EXT_VAL <= $urandom;
      @(negedge REF_CLK);
      chk(TIMER_EXT_CLOCK_IN, c[1] ? EXT_VAL[0] : EXT_VAL[6]);
      chk(EXT_IRQ_IN, c[0] ? EXT_VAL[6] : EXT_VAL[0]);
    end
    // Turning to output before any latch write
    wr(8'h04, 8'h00);
    @(negedge REF_CLK);
    chk({PIN_OE, PIN_OUT}, 16'hffff);
    rd(8'h00);
    wr(8'h00, $urandom);
    // Every code on both select registers
    for (c = 0; c < 4; c++) begin
      @(posedge REF_CLK);
      {SDA_OE, SCL_OE} <= 2'b00;
      wr(8'h10, 8'h55 * c);
      wr(8'h14, 8'h55 * c);
      TIMER_COMPARE_OUT <= $urandom;
      {SDA_OUT, SCL_OUT} <= ~c[1:0];
      {SDA_OE, SCL_OE} <= 2'b11;
      @(negedge REF_CLK);
      chk(TOUCH_KEY_SEL, c == 3 ? 4'hf : 4'h0);
      chk(key_small, c == 3 ? 4'h3 : 4'h0);
      chk({SDA_SEL, SCL_SEL}, c == 3 ? 2'h3 : 2'h0);
      chk(PIN_OUT[7], c == 3 ? TIMER_COMPARE_OUT : m[0][7]);
      if (c < 3) chk(PIN_OUT[2], c[1] ? !TIMER_COMPARE_OUT : m[0][2]);
    end
    @(posedge REF_CLK);
    {SDA_OE, SCL_OE} <= 2'b00;
    // Unimplemented bits, then back to plain I/O
    for (i = 2; i < 7; i++) wr(4 * i, 8'hff);
    for (i = 2; i < 7; i++) rd(4 * i);
    for (i = 3; i < 7; i++) wr(4 * i, 8'h00);
    // Bit set and clear on a half-input port
    wr(8'h04, 8'h0f);
    EXT_VAL <= $urandom;
    @(negedge REF_CLK);
    for (i = 0; i < 8; i++) begin
      wr(8'h1c, $urandom);
      rd(8'h00);
      rd(8'h04);
    end
    @(negedge REF_CLK);
    chk({PIN_OE, PIN_OUT & PIN_OE}, {~m[1][7:0], m[0][7:0] & ~m[1][7:0]});
    chk(PIN_PULL_EN, m[2] & m[1] & 8'hff);
    // Done event: raise, unmask, clear
    chk(IRQ, 0);
    wr(8'h28, 8'h02);
    @(negedge REF_CLK);
    chk(IRQ, 1);
    rd(8'h24);
    wr(8'h24, 8'h02);
    @(negedge REF_CLK);
    chk(IRQ, 0);
    // Falling edge on an enabled input during halt
    wr(8'h04, 8'hff);
    EXT_VAL <= 8'hff;
    wr(8'h0c, 8'h01);
    wr(8'h20, 8'h01);
    EXT_VAL <= 8'hfe;
    for (i = 0; i < 20 && WAKE !== 1'b1; i++) @(negedge REF_CLK);
    chk(WAKE, 1);
    m[8] = 0;
    m[9] |= 1;
    rd(8'h20);
    rd(8'h24);
    // Frozen clock enable: no handshake and no answer until it returns
    @(posedge REF_CLK);
    CLK_EN <= 0;
    S_AXI_ARADDR <= 8'h04;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    repeat (3) @(negedge REF_CLK);
    chk({S_AXI_ARREADY, S_AXI_RVALID}, 2'b00);
    @(posedge REF_CLK);
    CLK_EN <= 1;
    @(posedge REF_CLK);
    S_AXI_ARVALID <= 0;
    @(negedge REF_CLK);
    chk({S_AXI_RVALID, S_AXI_RDATA}, {1'b1, m[1]});
    @(posedge REF_CLK);
    S_AXI_RREADY <= 0;
    // Unmapped offset answers with an error and zero data
    xfer(1, 8'h30, 8'h5a);
    chk(rsp, 2'b10);
    xfer(0, 8'h30, 8'h00);
    chk({rsp, q}, {2'b10, 32'h0});
    summarize;
  end
endmodule

// File: hw/port_a_pin_function_mux.v
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module port_a_pin_function_mux #(
  parameter LARGE = 1
) (
  input wire REF_CLK,
  input wire RST,
  input wire CLK_EN,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [7:0] PIN_IN,
  output wire [7:0] PIN_OUT,
  output wire [7:0] PIN_OE,
  output wire [7:0] PIN_PULL_EN,
  output wire [3:0] TOUCH_KEY_SEL,
  input wire TIMER_COMPARE_OUT,
  output wire TIMER_EXT_CLOCK_IN,
  output wire EXT_IRQ_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  output wire SDA_IN,
  input wire SCL_OUT,
  input wire SCL_OE,
  output wire SCL_IN,
  output wire SDA_SEL,
  output wire SCL_SEL,
  output wire WAKE,
  output wire IRQ
);
`include "pin_mux_defs.vh"

  localparam [7:0] LOW_MASK = LARGE ? `SEL_LOW_MASK_LARGE :
    `SEL_LOW_MASK_SMALL;
  localparam [7:0] HIGH_MASK = LARGE ? `SEL_HIGH_MASK : 8'h00;
  localparam [7:0] SRC_MASK = LARGE ? `SRC_SEL_MASK : 8'h00;
  localparam [7:0] PORT_MASK = LARGE ? 8'hff : 8'h0f;

  reg [7:0] data_q;
  reg [7:0] dir_q;
  reg [7:0] pull_q;
  reg [7:0] wake_en_q;
  reg [7:0] pin_function_select_low;
  reg [7:0] pin_function_select_high;
  reg [7:0] input_source_select;
  reg halt_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [7:0] pin_prev_q;
  reg [7:0] awaddr_q;
  reg aw_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_full_q;

  // Per-pin function decode
  wire [1:0] f_pin0 = pin_function_select_low[1:0];
  wire [1:0] f_pin1 = pin_function_select_low[3:2];
  wire [1:0] f_pin2 = pin_function_select_low[5:4];
  wire [1:0] f_pin3 = pin_function_select_low[7:6];
  wire [1:0] f_pin4 = pin_function_select_high[1:0];
  wire [1:0] f_pin5 = pin_function_select_high[3:2];
  wire [1:0] f_pin7 = pin_function_select_high[7:6];

  // Small part maps its PA3/PA1 fields to pins three and one
  wire touch_key_three_sel = LARGE && f_pin3 == `CODE_ALT3;
  wire pin1_key = f_pin1 == `CODE_ALT3;
  wire pin3_key = f_pin3 == `CODE_ALT3;
  wire cmpb_sel = LARGE && f_pin2 == `CODE_ALT2;
  assign SDA_SEL = LARGE && f_pin2 == `CODE_ALT3;
  assign SCL_SEL = LARGE && f_pin0 == `CODE_ALT3;
  wire cmp_sel = LARGE && f_pin7 == `CODE_ALT3;
  wire touch_key_one_pin5 = LARGE && f_pin5 == `CODE_ALT3;
  wire touch_key_four_sel = LARGE && f_pin4 == `CODE_ALT3;

  // Touch key routing differs per variant
  assign TOUCH_KEY_SEL[0] = LARGE ? touch_key_one_pin5 : pin1_key;
  assign TOUCH_KEY_SEL[1] = LARGE ? pin1_key : pin3_key;
  assign TOUCH_KEY_SEL[2] = touch_key_three_sel;
  assign TOUCH_KEY_SEL[3] = touch_key_four_sel;

  // Pins that have left general I/O
  wire [7:0] alt_sel = {cmp_sel, 1'b0, touch_key_one_pin5, touch_key_four_sel,
    pin3_key, SDA_SEL | cmpb_sel, pin1_key, SCL_SEL};

  // Pin drivers; open-drain I2C lines drive low only
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      reg out_b;
      reg oe_b;
      always @* begin
        out_b = data_q[g];
        oe_b = ~dir_q[g] & ~alt_sel[g] & PORT_MASK[g];
        if (g == 2 && cmpb_sel) begin
          out_b = ~TIMER_COMPARE_OUT;
          oe_b = 1'b1;
        end else if (g == 2 && SDA_SEL) begin
          out_b = 1'b0;
          oe_b = SDA_OE & ~SDA_OUT;
        end else if (g == 0 && SCL_SEL) begin
          out_b = 1'b0;
          oe_b = SCL_OE & ~SCL_OUT;
        end else if (g == 7 && cmp_sel) begin
          out_b = TIMER_COMPARE_OUT;
          oe_b = 1'b1;
        end
      end
      assign PIN_OUT[g] = out_b;
      assign PIN_OE[g] = oe_b;
    end
  endgenerate

  // Pull-ups only make sense on general inputs
  assign PIN_PULL_EN = pull_q & dir_q & ~alt_sel & PORT_MASK;
  assign SDA_IN = PIN_IN[2];
  assign SCL_IN = PIN_IN[0];

  // Input source steering; small part has only pin zero
  assign TIMER_EXT_CLOCK_IN = (LARGE && !input_source_select[1]) ?
    PIN_IN[6] : PIN_IN[0];
  assign EXT_IRQ_IN = (LARGE && input_source_select[0]) ?
    PIN_IN[6] : PIN_IN[0];

  // Read value: inputs show the pin, outputs the latch
  wire [7:0] port_rd = ((dir_q & PIN_IN) | (~dir_q & data_q)) &
    PORT_MASK;

  // Wake: falling edge on enabled general inputs while halted
  wire [7:0] fall = pin_prev_q & ~PIN_IN;
  wire wake_hit = halt_q &
    |(fall & wake_en_q & dir_q & ~alt_sel & PORT_MASK);
  assign WAKE = wake_hit;

  // Bus write channel: both halves buffered, either order
  assign S_AXI_AWREADY = ~aw_full_q & ~S_AXI_BVALID & CLK_EN; // Frozen: none
  assign S_AXI_WREADY = ~w_full_q & ~S_AXI_BVALID & CLK_EN;
  wire wr_go = aw_full_q & w_full_q & ~S_AXI_BVALID;
  wire wr_lane = wstrb_q[0];
  wire [7:0] wb = wdata_q[7:0];
  wire [2:0] bit_idx = wb[`BITOP_IDX_LSB+2:`BITOP_IDX_LSB];
  wire bit_val = wb[`BITOP_SET_BIT];
  wire wr_hit = awaddr_q == `OFS_PORT_DATA || awaddr_q == `OFS_PORT_DIR ||
    awaddr_q == `OFS_PORT_PULL || awaddr_q == `OFS_PORT_WAKE ||
    awaddr_q == `OFS_SEL_LOW || awaddr_q == `OFS_SEL_HIGH ||
    awaddr_q == `OFS_SRC_SEL || awaddr_q == `OFS_BIT_OP ||
    awaddr_q == `OFS_CTRL || awaddr_q == `OFS_IRQ_STAT ||
    awaddr_q == `OFS_IRQ_MASK || awaddr_q == `OFS_PIN_LEVEL;

  // Read-modify-write of a whole byte for bit ops
  reg [7:0] rmw_src;
  reg [7:0] rmw_byte;
  always @* begin
    rmw_src = wb[`BITOP_DIR_BIT] ? dir_q : port_rd;
    rmw_byte = rmw_src;
    rmw_byte[bit_idx] = bit_val;
  end
  wire bitop_go = wr_go && wr_lane && awaddr_q == `OFS_BIT_OP;

  // Event sources for status
  wire [1:0] ev = {bitop_go, wake_hit};

  // Bus write side and register file
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      data_q <= `RST_PORT_DATA;
      dir_q <= `RST_PORT_DIR;
      pull_q <= `RST_ZERO;
      wake_en_q <= `RST_ZERO;
      pin_function_select_low <= `RST_ZERO;
      pin_function_select_high <= `RST_ZERO;
      input_source_select <= `RST_ZERO;
      halt_q <= 1'b0;
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      pin_prev_q <= 8'hff;
    end else if (CLK_EN) begin
      pin_prev_q <= PIN_IN;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      // Wake leaves halt; software write below may re-enter it
      if (wake_hit)
        halt_q <= 1'b0;
      // Status: set wins over write-one-to-clear
      irq_stat_q <= irq_stat_q | ev;
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_lane) begin
          if (awaddr_q == `OFS_PORT_DATA) begin
            data_q <= wb & PORT_MASK;
          end else if (awaddr_q == `OFS_PORT_DIR) begin
            dir_q <= wb | ~PORT_MASK;
          end else if (awaddr_q == `OFS_PORT_PULL) begin
            pull_q <= wb & PORT_MASK;
          end else if (awaddr_q == `OFS_PORT_WAKE) begin
            wake_en_q <= wb & PORT_MASK;
          end else if (awaddr_q == `OFS_SEL_LOW) begin
            pin_function_select_low <= wb & LOW_MASK;
          end else if (awaddr_q == `OFS_SEL_HIGH) begin
            pin_function_select_high <= wb & HIGH_MASK;
          end else if (awaddr_q == `OFS_SRC_SEL) begin
            input_source_select <= wb & SRC_MASK;
          end else if (awaddr_q == `OFS_BIT_OP) begin
            if (wb[`BITOP_DIR_BIT])
              dir_q <= rmw_byte | ~PORT_MASK;
            else
              data_q <= rmw_byte & PORT_MASK;
          end else if (awaddr_q == `OFS_CTRL) begin
            halt_q <= wb[`CTRL_HALT_BIT];
          end else if (awaddr_q == `OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb[1:0]) | ev;
          end else if (awaddr_q == `OFS_IRQ_MASK) begin
            irq_mask_q <= wb[1:0];
          end
        end
      end
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // Read side: one read at a time, answer one cycle after address
  assign S_AXI_ARREADY = ~S_AXI_RVALID & CLK_EN; // No lost frozen handshake
  reg [7:0] rd_byte;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR[7:2] == `OFS_PORT_DATA >> 2)
      rd_byte = port_rd;
    else if (S_AXI_ARADDR[7:2] == `OFS_PORT_DIR >> 2)
      rd_byte = dir_q & PORT_MASK;
    else if (S_AXI_ARADDR[7:2] == `OFS_PORT_PULL >> 2)
      rd_byte = pull_q;
    else if (S_AXI_ARADDR[7:2] == `OFS_PORT_WAKE >> 2)
      rd_byte = wake_en_q;
    else if (S_AXI_ARADDR[7:2] == `OFS_SEL_LOW >> 2)
      rd_byte = pin_function_select_low;
    else if (S_AXI_ARADDR[7:2] == `OFS_SEL_HIGH >> 2)
      rd_byte = pin_function_select_high;
    else if (S_AXI_ARADDR[7:2] == `OFS_SRC_SEL >> 2)
      rd_byte = input_source_select;
    else if (S_AXI_ARADDR[7:2] == `OFS_BIT_OP >> 2)
      rd_byte = 8'h00;
    else if (S_AXI_ARADDR[7:2] == `OFS_CTRL >> 2)
      rd_byte = {7'h00, halt_q};
    else if (S_AXI_ARADDR[7:2] == `OFS_IRQ_STAT >> 2)
      rd_byte = {6'h00, irq_stat_q};
    else if (S_AXI_ARADDR[7:2] == `OFS_IRQ_MASK >> 2)
      rd_byte = {6'h00, irq_mask_q};
    else if (S_AXI_ARADDR[7:2] == `OFS_PIN_LEVEL >> 2)
      rd_byte = PIN_IN & PORT_MASK;
    else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h000000, rd_byte};
        S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule
